// ---- pkg/sync_pkg.sv ----
// Shared types and constants for the OFDM acquisition core
package sync_pkg;
   localparam int SAMPLE_W = 8;
   typedef struct packed {
      logic signed [SAMPLE_W-1:0] re;
      logic signed [SAMPLE_W-1:0] im;
   } sample_t;

   localparam int IDX_W = 19;
   localparam int MARGIN_W = 16;
   localparam int THR_W = 8;
   localparam int THR_FRAC = 8;
   localparam int CFO_W = 16;
   typedef struct packed {
      logic [IDX_W-1:0] frameFirstSampleIndex;
      logic signed [CFO_W-1:0] cfoHz;
   } sync_result_t;

   // Cross-correlation path
   localparam int DECIM = 16;
   localparam int DECIM_LOG2 = 4;
   localparam int XC_LEN = 128;
   localparam logic [XC_LEN-1:0] PSS_RE = 128'h3a5c_96e1_0f4b_d278_c31e_65a9_b04d_7f12;
   localparam logic [XC_LEN-1:0] PSS_IM = 128'h9d07_4ae3_61bc_f528_0e93_d74a_2cb6_58f1;
   localparam int PEAK_FACTOR_LOG2 = 3;
   localparam int LOCK_FRAMES = 3;
   localparam int POS_TOL_DEC = 5;
   localparam int XC_LAG = (XC_LEN - 1) * DECIM;

   // Autocorrelation path
   localparam int NFFT = 2048;
   localparam int NFFT_W = 11;
   localparam int CP_LEN = 144;
   localparam int CP_W = 8;
   localparam int AC_MIN_RUN = 8;
   localparam int RUN_W = 4;
   localparam int AC_LAG = NFFT + CP_LEN;
   localparam int PROD_W = 2 * SAMPLE_W + 1;
   localparam int EN_W = 2 * SAMPLE_W + 2;
   localparam int ACC_P_W = PROD_W + CP_W;
   localparam int ACC_R_W = EN_W + CP_W;
   localparam int NUM_W = 2 * ACC_P_W;
   localparam int MET_W = 24;
   typedef struct packed {
      logic signed [PROD_W-1:0] re;
      logic signed [PROD_W-1:0] im;
      logic [EN_W-1:0] en;
   } ac_term_t;

   // Combining and frame index
   localparam int START_TOL = 16;
   localparam int PSS_SYMBOL = 7;
   localparam int SYM_LEN = NFFT + CP_LEN;
   localparam int PSS_OFFSET = (PSS_SYMBOL - 1) * SYM_LEN;
   localparam int SC_SPACING_HZ = 15000;

   typedef enum logic [1:0] {
      ST_ACQUIRE = 2'b00,
      ST_ANGLE = 2'b01,
      ST_LOCKED = 2'b10
   } state_t;

   localparam int FIFO_DEPTH = 8;

   // Angle unit: pi maps to 2^15
   localparam int CORDIC_ITERS = 15;
   localparam int ANG_W = 16;
   localparam int CORDIC_W = ACC_P_W + 2;
   localparam logic [0:CORDIC_ITERS-1][ANG_W-1:0] ATAN_TAB = {
      16'h2000, 16'h12e4, 16'h09fb, 16'h0511, 16'h028b, 16'h0146,
      16'h00a3, 16'h0051, 16'h0029, 16'h0014, 16'h000a, 16'h0005,
      16'h0003, 16'h0001, 16'h0001};
   localparam logic [ANG_W-1:0] ANG_PI = 16'h8000;
endpackage

// ---- verilog/sample_fifo.sv ----
// Sample FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wrPtr_r;
   logic [AW-1:0] rdPtr_r;
   logic [AW:0] count_r;
   wire logic push;
   wire logic pop;

   assign inReady = (count_r != (AW+1)'(DEPTH));
   assign outValid = (count_r != '0);
   assign outData = mem_r[rdPtr_r];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always_ff @(posedge clk) begin
      if (reset) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            mem_r[wrPtr_r] <= inData;
            wrPtr_r <= (wrPtr_r == AW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
         end
         if (pop)
            rdPtr_r <= (rdPtr_r == AW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // sample_fifo
`default_nettype wire

// ---- verilog/angle_cordic.sv ----
// Iterative vectoring unit returning the phase of a complex value
`timescale 1ns/1ps
`default_nettype none
module angle_cordic (
   input wire logic clk,
   input wire logic reset,
   input wire logic start,
   input wire logic signed [sync_pkg::ACC_P_W-1:0] inRe,
   input wire logic signed [sync_pkg::ACC_P_W-1:0] inIm,
   output logic done,
   output logic signed [sync_pkg::ANG_W-1:0] angle
);
   localparam int W = sync_pkg::CORDIC_W;
   localparam int AW = sync_pkg::ANG_W;
   logic signed [W-1:0] x_r;
   logic signed [W-1:0] y_r;
   logic [AW-1:0] z_r;
   logic [3:0] iter_r;
   logic busy_r;
   logic done_r;
   wire logic signed [W-1:0] xs;
   wire logic signed [W-1:0] ys;
   wire logic neg;

   assign xs = x_r >>> iter_r;
   assign ys = y_r >>> iter_r;
   assign neg = y_r[W-1];
   assign done = done_r;
   assign angle = signed'(z_r);

   always_ff @(posedge clk) begin
      if (reset) begin
         x_r <= '0;
         y_r <= '0;
         z_r <= '0;
         iter_r <= '0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         if (start) begin
            // Left half plane folded by a rotation of pi
            x_r <= inRe[sync_pkg::ACC_P_W-1] ? -W'(inRe) : W'(inRe);
            y_r <= inRe[sync_pkg::ACC_P_W-1] ? -W'(inIm) : W'(inIm);
            z_r <= inRe[sync_pkg::ACC_P_W-1] ? sync_pkg::ANG_PI : '0;
            iter_r <= '0;
            busy_r <= 1'b1;
         end else if (busy_r) begin
            x_r <= neg ? x_r - ys : x_r + ys;
            y_r <= neg ? y_r + xs : y_r - xs;
            z_r <= neg ? z_r - sync_pkg::ATAN_TAB[iter_r]
                       : z_r + sync_pkg::ATAN_TAB[iter_r];
            iter_r <= iter_r + 1'b1;
            if (iter_r == 4'(sync_pkg::CORDIC_ITERS - 1)) begin
               busy_r <= 1'b0;
               done_r <= 1'b1;
            end
         end
      end
   end
endmodule // angle_cordic
`default_nettype wire

// ---- verilog/ofdm_initial_time_freq_sync.sv ----
// Initial OFDM time and frequency acquisition core
//
// Operation
// R1: Acquire coarsely first, then hand to tracking
// R2: Frame start by cross-, symbol by autocorrelation
// R3: Decimate samples by sixteen before cross-correlation
// R4: Cross-correlate over 128 reduced-rate samples
// R5: Fresh peak search every radio frame
// R6: Accept peak above eight times frame average
// R7: Frame detected after three consecutive accepted peaks
// R8: Peak positions within five reduced-rate samples
// R9: Squared energy-normalised metric, CP window, FFT lag
// R10: Above threshold, track running maximum start index
// R11: Below threshold, stop search, clear maximum
// R12: Symbol start valid after eight samples above
// R13: Valid signal when both agree within sixteen
// R14: Frame index: start minus symbols minus margin
// R15: Frequency offset from autocorrelation angle
// R16: Offset unambiguous below half subcarrier spacing
// R17: Threshold and margin held during a search
// R18: One-cycle detection pulse with index and offset
`timescale 1ns/1ps
`default_nettype none
module ofdm_initial_time_freq_sync #(
   parameter int FRAME_LEN = 307200
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic inValid,
   output logic inReady,
   input wire sync_pkg::sample_t inSample,
   input wire logic [sync_pkg::THR_W-1:0] threshold,
   input wire logic [sync_pkg::MARGIN_W-1:0] margin,
   input wire logic restart,
   output logic detected,
   output logic locked,
   output var sync_pkg::sync_result_t result
);
   localparam int IW = sync_pkg::IDX_W;
   localparam int TW = IW + 2;
   localparam int XL = sync_pkg::XC_LEN;
   localparam int PW = sync_pkg::ACC_P_W;
   localparam int RW = sync_pkg::ACC_R_W;
   localparam int MW = sync_pkg::MET_W;
   localparam int DEC_FRAME = FRAME_LEN / sync_pkg::DECIM;
   localparam int DW = IW - sync_pkg::DECIM_LOG2;
   localparam int NW = sync_pkg::NUM_W;
   localparam int EW = sync_pkg::EN_W;

   function automatic logic [IW-1:0] wrapSub(input logic [IW-1:0] a,
                                             input logic [IW:0] s);
      logic [TW-1:0] t;
      t = TW'(a) + TW'(2 * FRAME_LEN) - TW'(s);
      if (t >= TW'(2 * FRAME_LEN))
         t = t - TW'(2 * FRAME_LEN);
      if (t >= TW'(FRAME_LEN))
         t = t - TW'(FRAME_LEN);
      return t[IW-1:0];
   endfunction

   function automatic logic circNear(input logic [IW-1:0] a,
                                     input logic [IW-1:0] b,
                                     input int md, input int tol);
      logic [IW-1:0] d;
      d = (a >= b) ? a - b : b - a;
      return (int'(d) <= tol) || (int'(d) >= md - tol);
   endfunction

   function automatic logic [9:0] corrMag(input logic [2*XL-1:0] v);
      logic [9:0] c;
      c = '0;
      for (int k = 0; k < 2 * XL; k++)
         c = c + 10'(v[k]);
      return (c >= 10'(XL)) ? (c << 1) - 10'(2 * XL)
                            : 10'(2 * XL) - (c << 1);
   endfunction

   // Input buffering and stall
   sync_pkg::state_t state_r;
   sync_pkg::state_t state_nxt;
   sync_pkg::sample_t smp;
   wire logic fifoValid;
   wire logic coreReady;
   wire logic fire;

   assign coreReady = (state_r != sync_pkg::ST_ANGLE);
   assign fire = fifoValid && coreReady;

   sample_fifo #(
      .WIDTH($bits(sync_pkg::sample_t)),
      .DEPTH(sync_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .reset(reset),
      .inValid(inValid),
      .inReady(inReady),
      .inData(inSample),
      .outValid(fifoValid),
      .outReady(coreReady),
      .outData(smp)
   );

   // Sample position within the radio frame period
   logic [IW-1:0] frameCnt_r;
   wire logic decTick;
   assign decTick = fire &&
      (frameCnt_r[sync_pkg::DECIM_LOG2-1:0] == '0); // [R3]

   // Cross-correlation against the stored sequence signs
   logic [XL-1:0] lineRe_r;
   logic [XL-1:0] lineIm_r;
   wire logic [2*XL-1:0] agreeRe;
   wire logic [2*XL-1:0] agreeIm;
   for (genvar k = 0; k < XL; k++) begin : g_tap
      assign agreeRe[2*k] = ~(lineRe_r[k] ^ sync_pkg::PSS_RE[k]);
      assign agreeRe[2*k+1] = ~(lineIm_r[k] ^ sync_pkg::PSS_IM[k]);
      assign agreeIm[2*k] = ~(lineIm_r[k] ^ sync_pkg::PSS_RE[k]);
      assign agreeIm[2*k+1] = lineRe_r[k] ^ sync_pkg::PSS_IM[k];
   end
   wire logic [10:0] xMetric;
   assign xMetric = 11'(corrMag(agreeRe)) + 11'(corrMag(agreeIm)); // [R4]

   logic xEval_r;
   logic [DW-1:0] xPos_r;
   logic [10:0] frmMax_r;
   logic [DW-1:0] frmPos_r;
   logic [31:0] frmSum_r;
   logic [DW-1:0] lastPos_r;
   logic [1:0] lockCnt_r;
   wire logic xBetter;
   wire logic [10:0] newMax;
   wire logic [DW-1:0] newPos;
   wire logic [31:0] newSum;
   wire logic frmEnd;
   wire logic peakOk;
   wire logic posNear;
   wire logic xLocked;
   wire logic [IW-1:0] xStart;

   assign xBetter = xMetric > frmMax_r;
   assign newMax = xBetter ? xMetric : frmMax_r;
   assign newPos = xBetter ? xPos_r : frmPos_r;
   assign newSum = frmSum_r + 32'(xMetric);
   assign frmEnd = (xPos_r == DW'(DEC_FRAME - 1)); // [R5]
   assign peakOk = 48'(newMax) * 48'(DEC_FRAME) >
      (48'(newSum) << sync_pkg::PEAK_FACTOR_LOG2); // [R6]
   assign posNear = circNear(IW'(newPos), IW'(lastPos_r), DEC_FRAME,
      sync_pkg::POS_TOL_DEC); // [R8]
   assign xLocked = (lockCnt_r == 2'(sync_pkg::LOCK_FRAMES)); // [R7]
   assign xStart = wrapSub({lastPos_r, 4'h0},
      (IW+1)'(sync_pkg::XC_LAG)); // [R2]

   // Cyclic-prefix autocorrelation
   sync_pkg::sample_t sampMem_r [sync_pkg::NFFT];
   sync_pkg::ac_term_t cpMem_r [sync_pkg::CP_LEN];
   logic [sync_pkg::NFFT_W-1:0] sPtr_r;
   logic [sync_pkg::CP_W-1:0] cPtr_r;
   logic signed [PW-1:0] accPre_r;
   logic signed [PW-1:0] accPim_r;
   logic [RW-1:0] accR_r;
   sync_pkg::sample_t lagSmp;
   sync_pkg::ac_term_t newTerm;
   sync_pkg::ac_term_t oldTerm;

   assign lagSmp = sampMem_r[sPtr_r];
   assign oldTerm = cpMem_r[cPtr_r];
   assign newTerm.re = smp.re * lagSmp.re + smp.im * lagSmp.im; // [R9]
   assign newTerm.im = smp.im * lagSmp.re - smp.re * lagSmp.im;
   assign newTerm.en = $unsigned(EW'(smp.re) * EW'(smp.re) +
      EW'(smp.im) * EW'(smp.im) + EW'(lagSmp.re) * EW'(lagSmp.re) +
      EW'(lagSmp.im) * EW'(lagSmp.im));

   wire logic [sync_pkg::NUM_W-1:0] numFull;
   wire logic [sync_pkg::NUM_W-1:0] denFull;
   wire logic [MW-1:0] num;
   wire logic [MW-1:0] den;
   assign numFull = $unsigned(NW'(accPre_r) * NW'(accPre_r) +
      NW'(accPim_r) * NW'(accPim_r));
   assign denFull = accR_r[RW-1:1] * accR_r[RW-1:1]; // [R9]
   assign num = numFull[sync_pkg::NUM_W-1 -: MW];
   assign den = denFull[sync_pkg::NUM_W-1 -: MW];

   logic [sync_pkg::THR_W-1:0] thrHold_r;
   logic [sync_pkg::MARGIN_W-1:0] marginHold_r;
   logic searching_r;
   logic [sync_pkg::RUN_W-1:0] runLen_r;
   logic [MW-1:0] maxNum_r;
   logic [MW-1:0] maxDen_r;
   logic [IW-1:0] peakIdx_r;
   logic signed [PW-1:0] peakRe_r;
   logic signed [PW-1:0] peakIm_r;
   logic aHit_r;
   logic [IW-1:0] aStart_r;
   logic signed [PW-1:0] aRe_r;
   logic signed [PW-1:0] aIm_r;
   wire logic above;
   wire logic acBetter;
   wire logic runOk;

   assign above = {num, (sync_pkg::THR_FRAC)'(0)} >
      (MW + sync_pkg::THR_FRAC)'(32'(thrHold_r) * 32'(den));
   assign acBetter = 48'(num) * 48'(maxDen_r) >
      48'(maxNum_r) * 48'(den); // [R10]
   assign runOk = (runLen_r >= sync_pkg::RUN_W'(sync_pkg::AC_MIN_RUN));

   // Combining, angle and hand-over
   wire logic goAngle;
   wire logic angDone;
   wire logic signed [sync_pkg::ANG_W-1:0] angle;
   wire logic signed [31:0] cfoProd;
   logic [IW-1:0] frameIdx_r;
   logic signed [sync_pkg::CFO_W-1:0] cfo_r;
   logic detected_r;

   assign goAngle = aHit_r && (state_r == sync_pkg::ST_ACQUIRE) &&
      xLocked && circNear(aStart_r, xStart, FRAME_LEN,
      sync_pkg::START_TOL); // [R13]
   // Full angle range spans plus/minus half the subcarrier spacing
   assign cfoProd = 32'(angle) * 32'(sync_pkg::SC_SPACING_HZ); // [R15] [R16]

   angle_cordic u_angle (
      .clk(clk),
      .reset(reset),
      .start(goAngle),
      .inRe(aRe_r),
      .inIm(aIm_r),
      .done(angDone),
      .angle(angle)
   );

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         sync_pkg::ST_ACQUIRE: if (goAngle) state_nxt = sync_pkg::ST_ANGLE;
         sync_pkg::ST_ANGLE: if (angDone) state_nxt = sync_pkg::ST_LOCKED;
         sync_pkg::ST_LOCKED: if (restart) state_nxt = sync_pkg::ST_ACQUIRE;
         default: state_nxt = sync_pkg::ST_ACQUIRE;
      endcase
   end // [R1]

   assign detected = detected_r;
   assign locked = (state_r == sync_pkg::ST_LOCKED);
   assign result.frameFirstSampleIndex = frameIdx_r;
   assign result.cfoHz = cfo_r;

   // Sample paths
   always_ff @(posedge clk) begin
      if (reset) begin
         frameCnt_r <= '0;
         sPtr_r <= '0;
         cPtr_r <= '0;
         accPre_r <= '0;
         accPim_r <= '0;
         accR_r <= '0;
         lineRe_r <= '0;
         lineIm_r <= '0;
         xEval_r <= 1'b0;
         xPos_r <= '0;
         for (int i = 0; i < sync_pkg::NFFT; i++)
            sampMem_r[i] <= '0;
         for (int i = 0; i < sync_pkg::CP_LEN; i++)
            cpMem_r[i] <= '0;
      end else begin
         xEval_r <= decTick;
         if (fire) begin
            frameCnt_r <= (frameCnt_r == IW'(FRAME_LEN - 1)) ? '0
                          : frameCnt_r + 1'b1;
            sampMem_r[sPtr_r] <= smp;
            sPtr_r <= sPtr_r + 1'b1;
            cpMem_r[cPtr_r] <= newTerm;
            cPtr_r <= (cPtr_r == sync_pkg::CP_W'(sync_pkg::CP_LEN - 1)) ?
                      '0 : cPtr_r + 1'b1;
            accPre_r <= accPre_r + PW'(newTerm.re) - PW'(oldTerm.re); // [R9]
            accPim_r <= accPim_r + PW'(newTerm.im) - PW'(oldTerm.im);
            accR_r <= accR_r + RW'(newTerm.en) - RW'(oldTerm.en);
         end
         if (decTick) begin
            lineRe_r <= {lineRe_r[XL-2:0], smp.re[sync_pkg::SAMPLE_W-1]};
            lineIm_r <= {lineIm_r[XL-2:0], smp.im[sync_pkg::SAMPLE_W-1]};
            xPos_r <= frameCnt_r[IW-1:sync_pkg::DECIM_LOG2];
         end
      end
   end

   // Per-frame cross-correlation peak and lock count
   always_ff @(posedge clk) begin
      if (reset) begin
         frmMax_r <= '0;
         frmPos_r <= '0;
         frmSum_r <= '0;
         lastPos_r <= '0;
         lockCnt_r <= '0;
      end else if (xEval_r) begin
         frmMax_r <= frmEnd ? '0 : newMax; // [R5]
         frmPos_r <= newPos;
         frmSum_r <= frmEnd ? '0 : newSum;
         if (frmEnd) begin
            lastPos_r <= peakOk ? newPos : lastPos_r;
            if (!peakOk)
               lockCnt_r <= '0; // [R6]
            else if (lockCnt_r == '0 || !posNear)
               lockCnt_r <= 2'd1; // [R8]
            else if (!xLocked)
               lockCnt_r <= lockCnt_r + 1'b1; // [R7]
         end
      end
   end

   // Autocorrelation peak search
   always_ff @(posedge clk) begin
      if (reset) begin
         thrHold_r <= '0;
         marginHold_r <= '0;
         searching_r <= 1'b0;
         runLen_r <= '0;
         maxNum_r <= '0;
         maxDen_r <= '1;
         peakIdx_r <= '0;
         peakRe_r <= '0;
         peakIm_r <= '0;
         aHit_r <= 1'b0;
         aStart_r <= '0;
         aRe_r <= '0;
         aIm_r <= '0;
      end else begin
         aHit_r <= 1'b0;
         if (!searching_r) begin
            thrHold_r <= threshold; // [R17]
            if (state_r == sync_pkg::ST_ACQUIRE)
               marginHold_r <= margin; // [R17]
         end
         if (fire && above) begin
            searching_r <= 1'b1; // [R10]
            if (!runOk)
               runLen_r <= runLen_r + 1'b1;
            if (acBetter) begin
               maxNum_r <= num; // [R10]
               maxDen_r <= den;
               peakIdx_r <= frameCnt_r;
               peakRe_r <= accPre_r;
               peakIm_r <= accPim_r;
            end
         end else if (fire && searching_r) begin
            searching_r <= 1'b0; // [R11]
            runLen_r <= '0;
            maxNum_r <= '0; // [R11]
            maxDen_r <= '1;
            aHit_r <= runOk; // [R12]
            aStart_r <= wrapSub(peakIdx_r, (IW+1)'(sync_pkg::AC_LAG));
            aRe_r <= peakRe_r;
            aIm_r <= peakIm_r;
         end
      end
   end

   // Hand-over to tracking
   always_ff @(posedge clk) begin
      if (reset) begin
         state_r <= sync_pkg::ST_ACQUIRE;
         frameIdx_r <= '0;
         cfo_r <= '0;
         detected_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         detected_r <= angDone && (state_r == sync_pkg::ST_ANGLE); // [R18]
         if (goAngle)
            frameIdx_r <= wrapSub(aStart_r, (IW+1)'(sync_pkg::PSS_OFFSET) +
               (IW+1)'(marginHold_r)); // [R14]
         if (angDone)
            cfo_r <= cfoProd[31 -: sync_pkg::CFO_W]; // [R15]
      end
   end
endmodule // ofdm_initial_time_freq_sync
`default_nettype wire

// ---- tb/sync_properties.sv ----
// Port-level properties of the acquisition core
`timescale 1ns/1ps
`default_nettype none
module sync_properties #(
   parameter int FRAME_LEN = 307200
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic inValid,
   input wire logic inReady,
   input wire sync_pkg::sample_t inSample,
   input wire logic [sync_pkg::THR_W-1:0] threshold,
   input wire logic [sync_pkg::MARGIN_W-1:0] margin,
   input wire logic restart,
   input wire logic detected,
   input wire logic locked,
   input wire sync_pkg::sync_result_t result
);
   logic [31:0] takenCount_r;
   always_ff @(posedge clk) begin
      if (reset) takenCount_r <= 32'h0;
      else if (inValid && inReady) takenCount_r <= takenCount_r + 32'h1;
   end

   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   property p_reset_clear;
      disable iff (1'b0)
      reset |=> !detected && !locked && result == '0 && inReady;
   endproperty
   a_reset_clear: assert property (p_reset_clear)
      else $error("outputs not cleared by reset");
   property p_pulse_single;
      detected |=> !detected;
   endproperty
   a_pulse_single: assert property (p_pulse_single)
      else $error("detection pulse longer than one cycle");
   property p_pulse_locks;
      detected |-> $rose(locked);
   endproperty
   a_pulse_locks: assert property (p_pulse_locks)
      else $error("lock not entered with the pulse");
   property p_result_hold;
      locked ##1 locked |-> $stable(result);
   endproperty
   a_result_hold: assert property (p_result_hold)
      else $error("result moved while locked");
   property p_locked_hold;
      locked && !restart |=> locked;
   endproperty
   a_locked_hold: assert property (p_locked_hold)
      else $error("lock lost without restart");
   property p_restart_exit;
      locked && restart |=> !locked;
   endproperty
   a_restart_exit: assert property (p_restart_exit)
      else $error("restart ignored");
   property p_three_frames;
      detected |-> takenCount_r >= 2 * FRAME_LEN;
   endproperty
   a_three_frames: assert property (p_three_frames)
      else $error("detection before three frames");
   property p_index_range;
      detected |-> result.frameFirstSampleIndex < FRAME_LEN;
   endproperty
   a_index_range: assert property (p_index_range)
      else $error("frame index outside frame");
   property p_cfo_range;
      detected |-> result.cfoHz > -16'sh1d4d && result.cfoHz < 16'sh1d4c;
   endproperty
   a_cfo_range: assert property (p_cfo_range)
      else $error("offset beyond half subcarrier spacing");
   property p_stall_bounded;
      $fell(inReady) |-> ##[1:40] inReady;
   endproperty
   a_stall_bounded: assert property (p_stall_bounded)
      else $error("input held off too long");
endmodule // sync_properties
`default_nettype wire

// ---- tb/sample_source.sv ----
// Front-end model streaming baseband samples into the core
`timescale 1ns/1ps
`default_nettype none
module sample_source #(
   parameter int FRAME_LEN = 8192,
   parameter int SYM_AT = 3008
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic sigOn,
   input wire logic gaps,
   input wire logic inReady,
   output logic inValid,
   output var sync_pkg::sample_t inSample
);
   int pos = 0;
   logic stall;

   // One symbol whose head repeats after the FFT span
   function automatic sync_pkg::sample_t make_sample(input int p);
      sync_pkg::sample_t s;
      int k;
      k = p - SYM_AT;
      s.re = 8'($urandom_range(14)) - 8'h07;
      s.im = 8'($urandom_range(14)) - 8'h07;
      if (sigOn && k >= 0 && k < sync_pkg::SYM_LEN) begin
         k = k % sync_pkg::NFFT;
         s.re = 8'((k * 37) % 80) - 8'h28;
         s.im = 8'((k * 53) % 80) - 8'h28;
         if (k % sync_pkg::DECIM == 0) begin
            // Sequence sent in the core's tap order, oldest tap first
            s.re = sync_pkg::PSS_RE[sync_pkg::XC_LEN - 1 - k / 16] ?
                   8'hd8 : 8'h28;
            s.im = sync_pkg::PSS_IM[sync_pkg::XC_LEN - 1 - k / 16] ?
                   8'hd8 : 8'h28;
         end
      end
      return s;
   endfunction

   initial begin
      inValid = 1'b0;
      inSample = '0;
   end

   // Offer held until taken, idle data scrambled
   always @(posedge clk) begin
      stall = inValid && !inReady;
      if (reset) pos = 0;
      else if (inValid && inReady) pos = (pos + 1) % FRAME_LEN;
      #1;
      if (reset) begin
         inValid = 1'b0;
         inSample = ~inSample;
      end else if (!stall) begin
         inValid = !(gaps && $urandom_range(3) == 0);
         inSample = inValid ? make_sample(pos) : ~inSample;
      end
   end
endmodule // sample_source
`default_nettype wire

// ---- tb/ofdm_initial_time_freq_sync_tb.sv ----
// Self-checking bench for the acquisition core
`timescale 1ns/1ps
`default_nettype none
module ofdm_initial_time_freq_sync_tb;
   localparam int FRAME_LEN = 8192;
   localparam int SYM_AT = 3008;
   logic clk = 1'b0;
   logic reset, inValid, inReady, sigOn, gaps, restart, detected, locked;
   logic sawFull = 1'b0;
   logic [sync_pkg::THR_W-1:0] threshold;
   logic [sync_pkg::MARGIN_W-1:0] margin;
   sync_pkg::sample_t inSample;
   sync_pkg::sync_result_t result;
   int numErrors = 0;
   int testsRun = 0;
   int waited;
   int mg;

   always #25 clk = ~clk;
   always @(posedge clk) if (inReady === 1'b0) sawFull <= 1'b1;

   ofdm_initial_time_freq_sync #(.FRAME_LEN(FRAME_LEN)) uut (
      .clk(clk), .reset(reset), .inValid(inValid), .inReady(inReady),
      .inSample(inSample), .threshold(threshold), .margin(margin),
      .restart(restart), .detected(detected), .locked(locked),
      .result(result));

   sample_source #(.FRAME_LEN(FRAME_LEN), .SYM_AT(SYM_AT)) src (
      .clk(clk), .reset(reset), .sigOn(sigOn), .gaps(gaps),
      .inReady(inReady), .inValid(inValid), .inSample(inSample));

   task automatic completeRun();
      $display("checks %0d errors %0d", testsRun, numErrors);
      if (numErrors == 0 && testsRun > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic check_bit(input logic got, input logic exp, string msg);
      testsRun++;
      if (got !== exp) begin
         numErrors++;
         $display("CHECK FAILED %0t %s", $time, msg);
      end
   endtask

   // Distance taken modulo the span
   task automatic check_near(input logic [31:0] got, input int exp,
         input int tol, input int span, input string msg);
      logic [31:0] d;
      d = (got + 32'(span) - 32'(exp)) % 32'(span);
      check_bit(d <= 32'(tol) || d >= 32'(span - tol), 1'b1, msg);
   endtask

   function automatic int exp_index(input int m);
      int x;
      x = (SYM_AT - sync_pkg::PSS_OFFSET - m) % FRAME_LEN;
      return (x + FRAME_LEN) % FRAME_LEN;
   endfunction

   task automatic wait_detect(input int limit);
      waited = 0;
      while (detected !== 1'b1) begin
         @(posedge clk);
         #1;
         waited++;
         if (waited > limit) begin
            numErrors++;
            $display("CHECK FAILED %0t no detection", $time);
            completeRun();
         end
      end
   endtask

   task automatic watch_quiet(input int cycles, input string msg);
      logic seen;
      seen = 1'b0;
      repeat (cycles) begin
         @(posedge clk);
         #1;
         seen = seen | detected;
      end
      check_bit(seen, 1'b0, msg);
   endtask

   task automatic check_detection(input int m);
      logic [31:0] idx;
      idx = 32'(result.frameFirstSampleIndex);
      check_bit(locked, 1'b1, "locked with pulse");
      check_near(idx, exp_index(m), 16, FRAME_LEN, "index");
      check_near({16'h0, result.cfoHz}, 0, 100, 65536, "offset");
      @(posedge clk);
      #1;
      check_bit(detected, 1'b0, "pulse width");
   endtask

   initial begin
      void'($urandom(9));
      reset = 1'b1;
      sigOn = 1'b0;
      gaps = 1'b1;
      restart = 1'b0;
      threshold = 8'h60 + 8'($urandom_range(64));
      mg = $urandom_range(200);
      margin = 16'(mg);
      repeat (4) @(posedge clk);
      #1;
      reset = 1'b0;
      check_bit(inReady, 1'b1, "ready after reset");
      check_bit(result == '0, 1'b1, "result after reset");
      watch_quiet(FRAME_LEN, "noise only");
      gaps = 1'b0;
      sigOn = 1'b1;
      wait_detect(5 * FRAME_LEN);
      check_bit(waited >= 2 * FRAME_LEN, 1'b1, "frame count");
      check_detection(mg);
      check_bit(sawFull, 1'b1, "input held off");
      watch_quiet(FRAME_LEN, "locked repeat");
      mg = $urandom_range(200);
      margin = 16'(mg);
      restart = 1'b1;
      @(posedge clk);
      #1;
      check_bit(locked, 1'b0, "restart");
      restart = 1'b0;
      wait_detect(2 * FRAME_LEN);
      check_detection(mg);
      reset = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      check_bit(locked, 1'b0, "mid-run reset");
      reset = 1'b0;
      watch_quiet(64, "after reset");
      completeRun();
   end
endmodule // ofdm_initial_time_freq_sync_tb

bind ofdm_initial_time_freq_sync sync_properties #(.FRAME_LEN(FRAME_LEN)) chk (
   .clk(clk), .reset(reset), .inValid(inValid), .inReady(inReady),
   .inSample(inSample), .threshold(threshold), .margin(margin),
   .restart(restart), .detected(detected), .locked(locked),
   .result(result));
`default_nettype wire
